// ==== flash_host_pkg.sv ====
// package with command codes, addresses and timing counts for the flash host
package flash_host_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLOCK_MHZ          = 50;     // system clock rate
  localparam int PAUSE_US           = 10;     // pause after id entry/exit
  localparam int PAUSE_CYCLES       = PAUSE_US * CLOCK_MHZ;
  localparam int LOAD_GAP_US        = 150;    // longest gap between loads
  localparam int LOAD_GAP_CYCLES    = LOAD_GAP_US * CLOCK_MHZ;
  localparam int PU_READ_US         = 100;    // power-up to first read
  localparam int PU_READ_CYCLES     = PU_READ_US * CLOCK_MHZ;
  localparam int PU_WRITE_MS        = 5;      // power-up to first write
  localparam int PU_WRITE_CYCLES    = PU_WRITE_MS * 1000 * CLOCK_MHZ;
  localparam int WRITE_CYCLE_MS     = 10;     // longest internal write
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000 * CLOCK_MHZ;
  localparam int STROBE_CYCLES      = 4;      // strobe count; low for 5 cycles, 100 ns
  localparam int TIMER_W            = 20;     // unused; the delay timer is 32 bits

  // ****************************************
  // command addresses and data
  // ****************************************
  localparam logic [14:0] ADDR_5555 = 15'h5555;
  localparam logic [14:0] ADDR_2AAA = 15'h2aaa;
  localparam logic [15:0] D_AAAA    = 16'haaaa;
  localparam logic [15:0] D_5555    = 16'h5555;
  localparam logic [15:0] D_A0A0    = 16'ha0a0;
  localparam logic [15:0] D_8080    = 16'h8080;
  localparam logic [15:0] D_2020    = 16'h2020;
  localparam logic [15:0] D_1010    = 16'h1010;
  localparam logic [15:0] D_AA      = 16'h00aa;
  localparam logic [15:0] D_55      = 16'h0055;
  localparam logic [15:0] D_90      = 16'h0090;
  localparam logic [15:0] D_80      = 16'h0080;
  localparam logic [15:0] D_60      = 16'h0060;
  localparam logic [15:0] D_F0      = 16'h00f0;
  localparam int          POLL_BIT  = 7;      // polling status bit
  localparam int          TOGGLE_BIT = 6;     // toggling status bit

  // ****************************************
  // host commands
  // ****************************************
  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,  // plain array read
    CMD_PROG       = 3'h1,  // protected page word load
    CMD_PROT_ON    = 3'h2,  // enable software protection
    CMD_PROT_OFF   = 3'h3,  // disable software protection
    CMD_ERASE      = 3'h4,  // chip erase
    CMD_ID_ENTER   = 3'h5,  // three-write id entry
    CMD_ID_ENTER6  = 3'h6,  // six-write id entry
    CMD_ID_EXIT    = 3'h7   // id exit
  } cmd_t;

  // a command prefix is one of these fixed write lists
  function automatic int seq_len(input cmd_t c);
    unique case (c)
      CMD_PROT_OFF, CMD_ERASE, CMD_ID_ENTER6: seq_len = 6;
      CMD_READ:                               seq_len = 0;
      default:                                seq_len = 3;
    endcase
  endfunction

endpackage

// ==== flash_bus_if.sv ====
// interface carrying one word-bus cycle between sequencer and pin driver
interface flash_bus_if;
  logic        start;   // pulse: begin a cycle
  logic        write;   // cycle is a write
  logic [15:0] addr;    // word address
  logic [15:0] wdata;   // write data
  logic        done;    // pulse: cycle finished
  logic [15:0] rdata;   // captured read data

  modport master (output start, write, addr, wdata, input done, rdata);
  modport slave  (input start, write, addr, wdata, output done, rdata);
endinterface

// ==== flash_pin_driver.sv ====
// one read or write cycle on the flash pins
module flash_pin_driver (
  input  wire logic   clock,
  input  wire logic   reset,
  flash_bus_if.slave  bus,
  output logic        ce_n,
  output logic        oe_n,
  output logic        we_n,
  output logic [15:0] addr_pin,
  output logic [15:0] dq_out,
  output logic        dq_oe,
  input  wire logic [15:0] dq_in
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,  // pins quiet
    P_LOW  = 2'b01,  // strobe held low
    P_END  = 2'b10,  // write strobe back high, read data taken
    P_DONE = 2'b11   // captured word stands, report done
  } pin_state_t;

  pin_state_t  state, next_state;
  logic [2:0]  count, next_count;       // strobe low time
  logic        wr, next_wr;             // cycle kind
  logic [15:0] next_addr_pin, next_dq_out;
  logic [15:0] sync1, sync2;            // read data synchroniser
  logic [15:0] rdata, next_rdata;

  // next-state logic; strobe wide enough for 70 ns pulse and access
  always_comb
  begin
    next_state    = state;
    next_count    = count;
    next_wr       = wr;
    next_addr_pin = addr_pin;
    next_dq_out   = dq_out;
    next_rdata    = rdata;
    unique case (state)
      P_IDLE:
        if (bus.start)
        begin
          next_state    = P_LOW;
          next_count    = 3'(flash_host_pkg::STROBE_CYCLES);
          next_wr       = bus.write;
          next_addr_pin = bus.addr;
          next_dq_out   = bus.wdata;
        end
      P_LOW:
        if (count == 3'h0)
          next_state = P_END;
        else
          next_count = count - 3'h1;
      P_END:
      begin
        next_state = P_DONE;
        next_rdata = sync2;  // taken after two flops of settling
      end
      // done only once rdata holds this cycle's word, not the last one
      P_DONE:
        next_state = P_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state    <= P_IDLE;
      count    <= 3'h0;
      wr       <= 1'b0;
      addr_pin <= 16'h0000;
      dq_out   <= 16'h0000;
      rdata    <= 16'h0000;
      sync1    <= 16'h0000;
      sync2    <= 16'h0000;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      wr       <= next_wr;
      addr_pin <= next_addr_pin;
      dq_out   <= next_dq_out;
      rdata    <= next_rdata;
      sync1    <= dq_in;
      sync2    <= sync1;
    end
  end

  // strobes; data bus driven during whole write cycle
  assign ce_n      = (state == P_IDLE);
  assign we_n      = !(state == P_LOW && wr);
  assign oe_n      = !(state != P_IDLE && !wr);
  assign dq_oe     = (state != P_IDLE) && wr;
  assign bus.done  = (state == P_DONE);
  assign bus.rdata = rdata;

endmodule

// ==== flash_host_sequencer.sv ====
// host controller issuing command sequences to a word-wide flash
module flash_host_sequencer #(
  parameter int PU_WRITE_CYCLES    = flash_host_pkg::PU_WRITE_CYCLES,
  parameter int WRITE_CYCLE_CYCLES = flash_host_pkg::WRITE_CYCLE_CYCLES,
  parameter int PAUSE_CYCLES       = flash_host_pkg::PAUSE_CYCLES,
  parameter int PU_READ_CYCLES     = flash_host_pkg::PU_READ_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  cmd_valid,   // request strobe
  input  wire flash_host_pkg::cmd_t  cmd,         // requested operation
  input  wire logic [15:0]           cmd_addr,    // read/program address
  input  wire logic [15:0]           cmd_data,    // program data
  input  wire logic                  cmd_last,    // last word of page
  output logic                       cmd_ready,   // idle, may take request
  output logic                       resp_valid,  // read data valid pulse
  output logic [15:0]                resp_data,   // read data
  output logic                       busy_wait,   // waiting on write cycle
  output logic                       timeout,     // write cycle overran
  output logic                       id_mode,     // id mode believed on
  output logic                       protected_on,// protection believed on
  output logic                       ce_n,
  output logic                       oe_n,
  output logic                       we_n,
  output logic [15:0]                addr_pin,
  output logic [15:0]                dq_out,
  output logic                       dq_oe,
  input  wire logic [15:0]           dq_in
);

  // ****************************************
  // types and state
  // ****************************************
  typedef enum logic [2:0] {
    S_POWERUP = 3'b000,  // waiting after reset
    S_IDLE    = 3'b001,  // accepting commands
    S_PREFIX  = 3'b010,  // issuing command writes
    S_DATA    = 3'b011,  // issuing data word or read
    S_PAUSE   = 3'b100,  // fixed pause after id command
    S_POLL    = 3'b101   // polling for write completion
  } seq_state_t;

  seq_state_t                      state, next_state;
  flash_host_pkg::cmd_t            cur, next_cur;
  logic [2:0]                      step, next_step;
  logic [31:0]                     timer, next_timer;
  logic [31:0]                     since_pu, next_since_pu;
  logic                            waiting, next_waiting;   // bus cycle out
  logic                            last, next_last;
  logic [15:0]                     a_hold, next_a_hold;
  logic [15:0]                     d_hold, next_d_hold;
  logic [15:0]                     prev, next_prev;         // toggle compare
  logic                            first_poll, next_first_poll;
  logic                            next_id_mode, next_protected_on;
  logic                            next_timeout, next_resp_valid;
  logic [15:0]                     next_resp_data;

  flash_bus_if bus ();

  flash_pin_driver u_pins (
    .clock    (clock),
    .reset    (reset),
    .bus      (bus.slave),
    .ce_n     (ce_n),
    .oe_n     (oe_n),
    .we_n     (we_n),
    .addr_pin (addr_pin),
    .dq_out   (dq_out),
    .dq_oe    (dq_oe),
    .dq_in    (dq_in)
  );

  // ****************************************
  // command table
  // ****************************************
  // address and data of write n of a command
  function automatic logic [30:0] seq_word(input flash_host_pkg::cmd_t c,
                                           input logic [2:0] n);
    logic        wide;
    logic [15:0] d;
    logic [14:0] a;
    wide = (c == flash_host_pkg::CMD_PROG) ||
           (c == flash_host_pkg::CMD_PROT_ON) ||
           (c == flash_host_pkg::CMD_PROT_OFF) ||
           (c == flash_host_pkg::CMD_ERASE);
    a = (n == 3'd1 || n == 3'd4) ? flash_host_pkg::ADDR_2AAA
                                 : flash_host_pkg::ADDR_5555;
    unique case (n)
      3'd0, 3'd3: d = wide ? flash_host_pkg::D_AAAA : flash_host_pkg::D_AA;
      3'd1, 3'd4: d = wide ? flash_host_pkg::D_5555 : flash_host_pkg::D_55;
      3'd2:
        unique case (c)
          flash_host_pkg::CMD_ID_ENTER:  d = flash_host_pkg::D_90;
          flash_host_pkg::CMD_ID_ENTER6: d = flash_host_pkg::D_80;
          flash_host_pkg::CMD_ID_EXIT:   d = flash_host_pkg::D_F0;
          flash_host_pkg::CMD_PROT_OFF,
          flash_host_pkg::CMD_ERASE:     d = flash_host_pkg::D_8080;
          default:                       d = flash_host_pkg::D_A0A0;
        endcase
      default:
        unique case (c)
          flash_host_pkg::CMD_PROT_OFF:  d = flash_host_pkg::D_2020;
          flash_host_pkg::CMD_ERASE:     d = flash_host_pkg::D_1010;
          default:                       d = flash_host_pkg::D_60;
        endcase
    endcase
    seq_word = {a, d};
  endfunction

  // ****************************************
  // sequencer next state
  // ****************************************
  // every program write carries the prefix, so protection is never
  // assumed off by accident
  always_comb
  begin
    logic [30:0] w;
    w               = seq_word(cur, step);
    next_state      = state;
    next_cur        = cur;
    next_step       = step;
    next_timer      = (timer != 32'h0) ? timer - 32'h1 : 32'h0;
    next_since_pu   = (since_pu != 32'hffffffff) ? since_pu + 32'h1 : since_pu;
    next_waiting    = waiting;
    next_last       = last;
    next_a_hold     = a_hold;
    next_d_hold     = d_hold;
    next_prev       = prev;
    next_first_poll = first_poll;
    next_id_mode    = id_mode;
    next_protected_on = protected_on;
    next_timeout    = 1'b0;
    next_resp_valid = 1'b0;
    next_resp_data  = resp_data;
    bus.start       = 1'b0;
    bus.write       = 1'b1;
    bus.addr        = {1'b0, w[30:16]};
    bus.wdata       = w[15:0];
    unique case (state)
      S_POWERUP:
        if (since_pu >= 32'(PU_WRITE_CYCLES))
          next_state = S_IDLE;
      S_IDLE:
        if (cmd_valid)
        begin
          next_cur    = cmd;
          next_step   = 3'd0;
          next_a_hold = cmd_addr;
          next_d_hold = cmd_data;
          next_last   = cmd_last;
          next_state  = (cmd == flash_host_pkg::CMD_READ) ? S_DATA : S_PREFIX;
        end
      S_PREFIX:
        if (!waiting)
        begin
          bus.start    = 1'b1;
          next_waiting = 1'b1;
        end
        else if (bus.done)
        begin
          next_waiting = 1'b0;
          if (32'(step) + 1 < flash_host_pkg::seq_len(cur))
            next_step = step + 3'd1;
          else if (cur == flash_host_pkg::CMD_PROG)
            next_state = S_DATA;
          else
          begin
            unique case (cur)
              flash_host_pkg::CMD_PROT_ON:  next_protected_on = 1'b1;
              flash_host_pkg::CMD_PROT_OFF: next_protected_on = 1'b0;
              flash_host_pkg::CMD_ID_ENTER,
              flash_host_pkg::CMD_ID_ENTER6: next_id_mode = 1'b1;
              flash_host_pkg::CMD_ID_EXIT:   next_id_mode = 1'b0;
              default: ;
            endcase
            if (cur == flash_host_pkg::CMD_ERASE ||
                cur == flash_host_pkg::CMD_PROT_ON ||
                cur == flash_host_pkg::CMD_PROT_OFF)
            begin
              // erase and protect commands take no data word; poll out the write cycle
              next_state      = S_POLL;
              next_timer      = 32'(WRITE_CYCLE_CYCLES);
              next_first_poll = 1'b1;
            end
            else
            begin
              next_state = S_PAUSE;
              next_timer = 32'(PAUSE_CYCLES);
            end
          end
        end
      S_DATA:
      begin
        bus.write = (cur != flash_host_pkg::CMD_READ);
        bus.addr  = a_hold;
        bus.wdata = d_hold;
        if (!waiting && (bus.write || since_pu >= 32'(PU_READ_CYCLES)))
        begin
          bus.start    = 1'b1;
          next_waiting = 1'b1;
        end
        else if (waiting && bus.done)
        begin
          next_waiting = 1'b0;
          if (!bus.write)
          begin
            next_resp_valid = 1'b1;
            next_resp_data  = bus.rdata;
            next_state      = S_IDLE;
          end
          else if (last)
          begin
            // stop loading; device programs after its window
            next_state      = S_POLL;
            next_timer      = 32'(WRITE_CYCLE_CYCLES);
            next_first_poll = 1'b1;
          end
          else
            next_state = S_IDLE;  // next word must follow promptly
        end
      end
      S_PAUSE:
        if (timer == 32'h0)
          next_state = S_IDLE;
      S_POLL:
      begin
        // read the last word until the toggling bit stands still
        bus.write = 1'b0;
        bus.addr  = a_hold;
        if (!waiting)
        begin
          bus.start    = 1'b1;
          next_waiting = 1'b1;
        end
        else if (bus.done)
        begin
          next_waiting    = 1'b0;
          next_prev       = bus.rdata;
          next_first_poll = 1'b0;
          if (!first_poll && bus.rdata[flash_host_pkg::TOGGLE_BIT] ==
              prev[flash_host_pkg::TOGGLE_BIT])
            next_state = S_IDLE;
          else if (timer == 32'h0)
          begin
            next_timeout = 1'b1;
            next_state   = S_IDLE;
          end
        end
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  // register stage; id belief clears at reset like power loss
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state        <= S_POWERUP;
      cur          <= flash_host_pkg::CMD_READ;
      step         <= 3'd0;
      timer        <= 32'h0;
      since_pu     <= 32'h0;
      waiting      <= 1'b0;
      last         <= 1'b0;
      a_hold       <= 16'h0000;
      d_hold       <= 16'h0000;
      prev         <= 16'h0000;
      first_poll   <= 1'b0;
      id_mode      <= 1'b0;
      protected_on <= 1'b1;  // shipped protected
      timeout      <= 1'b0;
      resp_valid   <= 1'b0;
      resp_data    <= 16'h0000;
    end
    else
    begin
      state        <= next_state;
      cur          <= next_cur;
      step         <= next_step;
      timer        <= next_timer;
      since_pu     <= next_since_pu;
      waiting      <= next_waiting;
      last         <= next_last;
      a_hold       <= next_a_hold;
      d_hold       <= next_d_hold;
      prev         <= next_prev;
      first_poll   <= next_first_poll;
      id_mode      <= next_id_mode;
      protected_on <= next_protected_on;
      timeout      <= next_timeout;
      resp_valid   <= next_resp_valid;
      resp_data    <= next_resp_data;
    end
  end

  assign cmd_ready = (state == S_IDLE);
  assign busy_wait = (state == S_POLL);

  // ****************************************
  // checks
  // ****************************************
  chk_no_early_write: assert property (@(posedge clock) disable iff (reset)
    !we_n |-> since_pu >= 32'(PU_WRITE_CYCLES))
    else $error("write strobe before power-up delay");
  chk_read_delay: assert property (@(posedge clock) disable iff (reset)
    !oe_n |-> since_pu >= 32'(PU_READ_CYCLES))
    else $error("read before power-up read delay");
  chk_pause_hold: assert property (@(posedge clock) disable iff (reset)
    $rose(state == S_PAUSE) |-> ce_n [*8])
    else $error("bus active during pause");
  chk_first_cmd: assert property (@(posedge clock) disable iff (reset)
    (state == S_PREFIX && step == 3'd0 && bus.start) |->
    bus.addr[14:0] == flash_host_pkg::ADDR_5555)
    else $error("command does not open at 5555");
  chk_prot_seq: assert property (@(posedge clock) disable iff (reset)
    (state == S_PREFIX && cur == flash_host_pkg::CMD_PROT_ON && step == 3'd2
     && bus.start) |-> bus.wdata == flash_host_pkg::D_A0A0)
    else $error("wrong protect code");
  chk_erase_seq: assert property (@(posedge clock) disable iff (reset)
    (state == S_PREFIX && cur == flash_host_pkg::CMD_ERASE && step == 3'd5
     && bus.start) |-> bus.wdata == flash_host_pkg::D_1010)
    else $error("wrong erase code");
  chk_id_flag: assert property (@(posedge clock) disable iff (reset)
    $rose(id_mode) |-> $past(cur) != flash_host_pkg::CMD_ID_EXIT)
    else $error("id flag set by exit");
  chk_poll_bound: assert property (@(posedge clock) disable iff (reset)
    timeout |-> $past(state) == S_POLL)
    else $error("timeout outside polling");
  cov_erase: cover property (@(posedge clock) state == S_POLL &&
    cur == flash_host_pkg::CMD_ERASE);
  cov_id: cover property (@(posedge clock) $rose(id_mode));
  cov_read: cover property (@(posedge clock) resp_valid);

endmodule

// ==== flash_dev_model.sv ====
// behavioural word-wide flash device facing the host sequencer
module flash_dev_model #(
  parameter int          PU_W  = 40,
  parameter int          PU_R  = 10,
  parameter int          BUSY  = 100,
  parameter int          WIN   = 4,
  parameter logic [15:0] MAKER = 16'h0012, // arbitrary value
  parameter logic [15:0] PART  = 16'h0034  // arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        reset,     // stands for a power cycle
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] addr_pin,
  input  wire logic [15:0] dq_out,    // data written by the host
  input  wire logic        stall,     // stretch the write cycle
  output logic      [15:0] dq_in,     // data read by the host
  output logic             prot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0]      mem [256];     // small array, low address bits only
  logic [5:0][30:0] h;             // last six writes, slot 0 newest
  logic [15:0]      last = '0;     // word that status reads reflect
  logic [15:0]      drv = '0;      // last value driven
  logic [15:0]      lw;
  logic             pr = 1'b1;     // shipped protected
  logic             id, arm, tog, we_q, oe_q;
  int               pu, cnt, win;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign prot = pr;
  assign lw = mem[last[7:0]];
  // one write of a command matched at a history slot
  function automatic bit m(int i, logic [14:0] a, logic [15:0] d);
    return h[i] == {a, d};
  endfunction
  // three-write command ending in x; s picks the short codes
  function automatic bit p3(logic [15:0] x, bit s);
    return m(2, 15'h5555, s ? 16'h00aa : 16'haaaa) && m(0, 15'h5555, x)
      && m(1, 15'h2aaa, s ? 16'h0055 : 16'h5555);
  endfunction
  function automatic bit p6(logic [15:0] x, bit s);
    return m(5, 15'h5555, s ? 16'h00aa : 16'haaaa) && p3(x, s)
      && m(4, 15'h2aaa, s ? 16'h0055 : 16'h5555)
      && m(3, 15'h5555, s ? 16'h0080 : 16'h8080);
  endfunction
  // command matching and self-timed counters
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      id <= 1'b0; // id mode lost at power loss
      {arm, tog, pu, cnt, win} <= '0;
      {we_q, oe_q} <= 2'b11;
    end
    else
    begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (pu < PU_W) pu <= pu + 1; // power-up lockout timer
      if (cnt > 0) cnt <= cnt - 1; // internal write cycle
      if (win > 0) win <= win - 1;
      if (win == 1) arm <= 1'b0;
      if (win == 1) cnt <= stall ? 3000 : BUSY; // page closes
      if (!oe_n && oe_q && !ce_n && cnt > 0) tog <= !tog;
      if (!ce_n && !oe_n) drv <= dq_in;
      // a stray write leaves the history unmatched
      if (we_n && !we_q && !ce_n && pu >= PU_W)
      begin
        h = {h[4:0], addr_pin[14:0], dq_out}; // address bits 14..0
        pr <= p3(16'ha0a0, 0) ? 1'b1 : p6(16'h2020, 0) ? 1'b0 : pr;
        if (p3(16'ha0a0, 0)) arm <= 1'b1;
        else if (p6(16'h2020, 0)) cnt <= BUSY;
        else if (p6(16'h1010, 0)) cnt <= stall ? 3000 : BUSY;
        if (p6(16'h1010, 0)) foreach (mem[i]) mem[i] <= 16'hffff;
        if (p3(16'h0090, 1) || p6(16'h0060, 1)) id <= 1'b1;
        else if (p3(16'h00f0, 1)) id <= 1'b0;
        else if ((!pr || arm) && !p3(16'ha0a0, 0))
        begin
          mem[addr_pin[7:0]] <= dq_out;
          last <= addr_pin;
          win <= WIN;
        end
      end
    end
  end
  // read path; a released bus shows the inverse of the last value
  always_comb
  begin
    if (ce_n || oe_n || pu < PU_R) dq_in = ~drv;
    else if (id && addr_pin[15:1] == 15'h0)
      dq_in = addr_pin[0] ? PART : MAKER;
    else if (cnt > 0)
      dq_in = {~lw[15], tog, lw[13:8], ~lw[7], tog, lw[5:0]};
    else
      dq_in = mem[addr_pin[7:0]];
  end
endmodule

// ==== tb.sv ====
// self-checking bench for the flash host sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, reset = 1, cmd_valid = 0, cmd_last = 1;
  logic        stall = 0;
  logic [15:0] cmd_addr = '0, cmd_data = '0, resp_data, addr_pin;
  logic [15:0] dq_out, dq_in;
  logic        cmd_ready, resp_valid, busy_wait, timeout, id_mode;
  logic        protected_on, ce_n, oe_n, we_n, dq_oe, prot;
  int          n_errors = 0, checked = 0, cycles = 0;
  flash_host_pkg::cmd_t cmd = flash_host_pkg::CMD_READ;
  always #10 clock = ~clock;
  flash_host_sequencer #(.PU_WRITE_CYCLES(50), .PU_READ_CYCLES(20),
    .PAUSE_CYCLES(20), .WRITE_CYCLE_CYCLES(2000)) flash_host_sequencer_i (.*);
  flash_dev_model flash_dev_model_i (.*);
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // wait a bounded time for a flag, sampled mid-cycle
  task automatic wait_for(ref logic f, input int n);
    for (int i = 0; i < n && f !== 1'b1; i++) @(negedge clock);
    if (f !== 1'b1) chk(16'h0, 16'h1);
  endtask
  // hold a request until taken, then drop it
  task automatic issue(flash_host_pkg::cmd_t c, logic [15:0] a, d);
    @(posedge clock);
    cmd       <= c;
    cmd_addr  <= a;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    @(negedge clock);
    wait_for(cmd_ready, 300000);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
  endtask
  task automatic op(flash_host_pkg::cmd_t c);
    issue(c, 16'h0, 16'h0);
    wait_for(cmd_ready, 5000);
  endtask
  task automatic rd(logic [15:0] a, exp);
    issue(flash_host_pkg::CMD_READ, a, 16'h0);
    wait_for(resp_valid, 50);
    chk(resp_data, exp);
  endtask
  task automatic t_power();
    int n;
    for (n = 0; cmd_ready !== 1'b1 && n < 500; n++) @(negedge clock);
    chk(16'(n >= 50), 16'h1);
    chk(16'(protected_on), 16'h1);
    chk(16'(id_mode), 16'h0);
  endtask
  task automatic t_prog();
    @(posedge clock);
    cmd_last <= 1'b0;
    issue(flash_host_pkg::CMD_PROG, 16'h0011, 16'h5678);
    wait_for(cmd_ready, 500);
    chk(16'(busy_wait), 16'h0);
    @(posedge clock);
    cmd_last <= 1'b1;
    issue(flash_host_pkg::CMD_PROG, 16'h0010, 16'h1234);
    wait_for(busy_wait, 200);
    wait_for(cmd_ready, 5000);
    rd(16'h0010, 16'h1234);
    rd(16'h0011, 16'h5678);
  endtask
  task automatic t_id(flash_host_pkg::cmd_t c);
    op(c);
    chk(16'(id_mode), 16'h1);
    rd(16'h0000, 16'h0012);
    rd(16'h0001, 16'h0034);
    op(flash_host_pkg::CMD_ID_EXIT);
    chk(16'(id_mode), 16'h0);
    rd(16'h0010, 16'h1234);
  endtask
  task automatic t_prot();
    op(flash_host_pkg::CMD_PROT_OFF);
    chk({15'h0, protected_on}, {15'h0, prot});
    chk(16'(prot), 16'h0);
    op(flash_host_pkg::CMD_PROT_ON);
    chk(16'(protected_on & prot), 16'h1);
  endtask
  task automatic t_erase();
    op(flash_host_pkg::CMD_ERASE);
    rd(16'h0010, 16'hffff);
    @(posedge clock);
    stall <= 1'b1;
    issue(flash_host_pkg::CMD_ERASE, 16'h0, 16'h0);
    wait_for(timeout, 2600);
    wait_for(cmd_ready, 5000);
    stall <= 1'b0;
  endtask
  // second power cycle in mid-run, with id mode on
  task automatic t_repower();
    op(flash_host_pkg::CMD_ID_ENTER);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_power();
    rd(16'h0000, 16'hffff);
    chk(16'(prot), 16'h1);
  endtask
  // hang guard: the run needs well under this many cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_power();
    t_prog();
    t_id(flash_host_pkg::CMD_ID_ENTER);
    t_id(flash_host_pkg::CMD_ID_ENTER6);
    t_prot();
    t_erase();
    t_repower();
    conclude();
  end
endmodule
